/* core/ssbg_consts.svh */
// ---------------------------------------------------------------------------
// constants of the serial status flags and baud generator
// ---------------------------------------------------------------------------
// holds register offsets, field positions, reset values and counts
// assumes a 12-bit apb byte address and 32-bit data
`ifndef SSBG_CONSTS_SVH
`define SSBG_CONSTS_SVH

// register byte offsets
`define SSBG_OFF_STATUS   12'h000
`define SSBG_OFF_DIVISOR  12'h004
`define SSBG_OFF_CONTROL  12'h008
`define SSBG_OFF_TXHOLD   12'h00c
`define SSBG_OFF_RXBUF    12'h010

// reset values
`define SSBG_RST_STATUS   8'h84
`define SSBG_RST_DIVISOR  8'hff
`define SSBG_RST_CONTROL  8'h00

// status field positions
`define SSBG_ST_TXE       7
`define SSBG_ST_RXF       6
`define SSBG_ST_OVR       5
`define SSBG_ST_FER       4
`define SSBG_ST_PER       3
`define SSBG_ST_TX_DONE_FLAG      2
`define SSBG_ST_RXMARK    1
`define SSBG_ST_TXMARK    0

// control field positions
`define SSBG_CT_TXON      0
`define SSBG_CT_RXEN      1
`define SSBG_CT_SYNC      2
`define SSBG_CT_MP        3
`define SSBG_CT_PEN       4
`define SSBG_CT_PODD      5
`define SSBG_CT_CKS_LO    6
`define SSBG_CT_CKS_HI    7

// prescaler terminal counts for divide by 1, 4, 16, 64
`define SSBG_PRE_LIM1     6'h00
`define SSBG_PRE_LIM4     6'h03
`define SSBG_PRE_LIM16    6'h0f
`define SSBG_PRE_LIM64    6'h3f

// divided ticks per bit: 32 async (x 2 = 64 half), 4 sync
`define SSBG_SUB_ASYNC    5'h1f
`define SSBG_SUB_SYNC     5'h03

`endif

/* core/ssbg_pkg.sv */
// ---------------------------------------------------------------------------
// types of the serial status flags and baud generator
// ---------------------------------------------------------------------------
// holds the prescale code and the state record of the block
// assumes nothing beyond the constants header
package ssbg_pkg;

  // prescale select codes
  typedef enum logic [1:0] {
    SSBG_DIV1  = 2'h0,
    SSBG_DIV4  = 2'h1,
    SSBG_DIV16 = 2'h2,
    SSBG_DIV64 = 2'h3
  } ssbg_presc_e;

  // whole state of the block
  typedef struct packed {
    logic        tx_empty_flag;
    logic        rx_full_flag;
    logic        overrun_flag;
    logic        framing_fault_flag;
    logic        parity_fault_flag;
    logic        tx_done_flag;
    logic        rx_addr_mark_bit;
    logic        tx_addr_mark_bit;
    logic [4:0]  armed;
    logic [7:0]  bit_rate_divisor;
    logic [7:0]  control;
    logic [7:0]  tx_holding_reg;
    logic [7:0]  rx_buffer_reg;
    logic [7:0]  tx_shift_reg;
    logic        tx_mark_out;
    logic [5:0]  pre_cnt;
    logic [7:0]  div_cnt;
    logic [4:0]  sub_cnt;
    logic        sample_tick;
    logic        bit_tick;
    logic        rx_block;
    logic        tx_block;
    logic        tx_start_ok;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ssbg_state_s;

endpackage

/* core/ssbg_top.sv */
// ---------------------------------------------------------------------------
// serial status flags and baud generator, one channel
// ---------------------------------------------------------------------------
// holds the status flags, divisor, control and the baud tick generator
// assumes the frame shifters and dma agent run on pclk and pulse events
//
// Functional notes
// - tx empty clears on armed software zero write or dma holding write.
// - tx empty sets on reset, standby, transmitter off or shift load.
// - rx full sets when an error-free character lands in the buffer.
// - rx full clears on reset, standby, armed zero write or dma read.
// - errors and receiver off leave buffer and rx full untouched.
// - character while rx full sets overrun, discards it, keeps old byte.
// - any error flag stops receiving; sync mode also stops transmit.
// - receiver off keeps overrun, framing and parity flags.
// - async zero first stop bit sets framing fault.
// - framing fault still copies data but leaves rx full clear.
// - async parity mismatch sets parity fault; data copied, rx full clear.
// - error flags clear on reset, standby or armed zero write.
// - tx done clears with software tx empty clear or dma write.
// - tx done sets on reset, standby, transmitter off, or empty at end.
// - writes to tx done and rx address mark are ignored.
// - async multiprocessor receive captures the mark; kept when rx off.
// - async multiprocessor transmit appends tx mark; ignored otherwise.
// - 8-bit divisor always read/write, loads ff on reset and standby.
// - channel owns its divisor and generator; instantiate per channel.
// - bit time is (N+1)*2^(2n-1)*64 async, *8 sync system clocks.
// - prescale code 0..3 divides the clock by 1, 4, 16 or 64.
// - divisor takes any value 0 to 255.
// - one writes to flags do nothing; zero clears only after read as one.
//
// The register addresses and the APB slave port were left to the implementer.
`include "ssbg_consts.svh"

module ssbg_top (
  input  wire logic        pclk,            // system clock
  input  wire logic        presetn,         // async reset, active low
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb access phase
  input  wire logic        pwrite,          // apb write
  input  wire logic [11:0] paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic      [31:0] prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr,         // apb error, unmapped
  input  wire logic        standby,         // standby mode level
  input  wire logic        dma_wr,          // dma writes holding reg
  input  wire logic [7:0]  dma_wdata,       // dma byte to send
  input  wire logic        dma_rd,          // dma reads rx buffer
  output logic      [7:0]  dma_rdata,       // rx buffer for dma
  input  wire logic        tx_load,         // shifter takes holding reg
  input  wire logic        tx_last_bit,     // final bit sent
  output logic      [7:0]  tx_shift_data,   // byte in tx shifter
  output logic             tx_mark_out,     // appended multiproc bit
  output logic             tx_start_ok,     // holding reg may be loaded
  input  wire logic        rx_done,         // character finished
  input  wire logic [7:0]  rx_data,         // received byte
  input  wire logic        rx_parity_bit,   // received parity bit
  input  wire logic        rx_stop_bit,     // first stop bit
  input  wire logic        rx_mark_bit,     // received multiproc bit
  output logic             rx_block,        // receiving halted
  output logic             sample_tick,     // 16x bit rate tick async, 2x sync
  output logic             bit_tick         // one per bit time
);

  ssbg_pkg::ssbg_state_s st_r;
  ssbg_pkg::ssbg_state_s st_nxt;

  // -------------------------------------------------------------------------
  // decoded bus and mode terms
  // -------------------------------------------------------------------------
  logic        setup_ph;
  logic        acc_ph;
  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;
  logic        sync_mode;
  logic        mp_async;
  logic        err_any;
  logic        rx_take;
  logic        fer_hit;
  logic        per_hit;
  logic        sw_txe_clr;
  logic [5:0]  pre_lim;
  logic [4:0]  sub_lim;
  logic [7:0]  status_v;

  // bus phases and address decode
  assign setup_ph  = psel & ~penable;
  assign acc_ph    = psel & penable;
  assign wr_acc    = acc_ph & pwrite;
  assign rd_acc    = acc_ph & ~pwrite;
  assign mapped    = (paddr == `SSBG_OFF_STATUS)  |
                     (paddr == `SSBG_OFF_DIVISOR) |
                     (paddr == `SSBG_OFF_CONTROL) |
                     (paddr == `SSBG_OFF_TXHOLD)  |
                     (paddr == `SSBG_OFF_RXBUF);

  // mode terms from the control register, error term from the status flags
  assign sync_mode = st_r.control[`SSBG_CT_SYNC];
  assign mp_async  = st_r.control[`SSBG_CT_MP] & ~sync_mode;
  assign err_any   = st_r.overrun_flag | st_r.framing_fault_flag |
                     st_r.parity_fault_flag;

  assign rx_take   = rx_done & st_r.control[`SSBG_CT_RXEN] & ~err_any;

  assign fer_hit   = ~sync_mode & ~rx_stop_bit;

  assign per_hit   = ~sync_mode & st_r.control[`SSBG_CT_PEN] &
                     ((^{rx_data, rx_parity_bit}) !=
                      st_r.control[`SSBG_CT_PODD]);

  // zero write clears only an armed flag
  assign sw_txe_clr = wr_acc & (paddr == `SSBG_OFF_STATUS) &
                      ~pwdata[`SSBG_ST_TXE] & st_r.armed[4];

  // status image as software sees it
  assign status_v  = {st_r.tx_empty_flag, st_r.rx_full_flag,
                      st_r.overrun_flag, st_r.framing_fault_flag,
                      st_r.parity_fault_flag, st_r.tx_done_flag,
                      st_r.rx_addr_mark_bit, st_r.tx_addr_mark_bit};

  always_comb begin
    case (ssbg_pkg::ssbg_presc_e'({st_r.control[`SSBG_CT_CKS_HI],
                                   st_r.control[`SSBG_CT_CKS_LO]}))
      ssbg_pkg::SSBG_DIV1:  pre_lim = `SSBG_PRE_LIM1;
      ssbg_pkg::SSBG_DIV4:  pre_lim = `SSBG_PRE_LIM4;
      ssbg_pkg::SSBG_DIV16: pre_lim = `SSBG_PRE_LIM16;
      ssbg_pkg::SSBG_DIV64: pre_lim = `SSBG_PRE_LIM64;
      default:              pre_lim = `SSBG_PRE_LIM1;
    endcase
  end

  // divided ticks per bit by mode
  assign sub_lim = sync_mode ? `SSBG_SUB_SYNC : `SSBG_SUB_ASYNC;

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  // clears are applied first so that a set in the same cycle wins; standby is applied last and wins over both
  always_comb begin
    st_nxt = st_r;
    st_nxt.sample_tick = 1'b0;
    st_nxt.bit_tick    = 1'b0;

    // bus answer: data and error prepared in setup, ready held high
    st_nxt.pready = 1'b1;
    if (setup_ph) begin
      st_nxt.pslverr = ~mapped;
      case (paddr)
        `SSBG_OFF_STATUS:  st_nxt.prdata = {24'h000000, status_v};
        `SSBG_OFF_DIVISOR: st_nxt.prdata = {24'h000000,
                                            st_r.bit_rate_divisor};
        `SSBG_OFF_CONTROL: st_nxt.prdata = {24'h000000, st_r.control};
        `SSBG_OFF_TXHOLD:  st_nxt.prdata = {24'h000000,
                                            st_r.tx_holding_reg};
        `SSBG_OFF_RXBUF:   st_nxt.prdata = {24'h000000,
                                            st_r.rx_buffer_reg};
        default:           st_nxt.prdata = 32'h00000000;
      endcase
    end

    // a flag at zero loses its arming; a status read arms flags at one
    st_nxt.armed = st_r.armed & status_v[7:3];
    if (rd_acc && (paddr == `SSBG_OFF_STATUS)) begin
      st_nxt.armed = st_nxt.armed | status_v[7:3];
    end

    // register writes
    if (wr_acc) begin
      case (paddr)
        `SSBG_OFF_STATUS: begin
          // armed zero write clears tx empty
          if (sw_txe_clr) begin
            st_nxt.tx_empty_flag = 1'b0;
            // tx done follows tx empty clear
            st_nxt.tx_done_flag  = 1'b0;
            st_nxt.armed[4]      = 1'b0;
          end
          // armed zero write clears rx full
          if (!pwdata[`SSBG_ST_RXF] && st_r.armed[3]) begin
            st_nxt.rx_full_flag = 1'b0;
            st_nxt.armed[3]     = 1'b0;
          end
          // armed zero write clears error flags
          if (!pwdata[`SSBG_ST_OVR] && st_r.armed[2]) begin
            st_nxt.overrun_flag = 1'b0;
            st_nxt.armed[2]     = 1'b0;
          end
          if (!pwdata[`SSBG_ST_FER] && st_r.armed[1]) begin
            st_nxt.framing_fault_flag = 1'b0;
            st_nxt.armed[1]           = 1'b0;
          end
          if (!pwdata[`SSBG_ST_PER] && st_r.armed[0]) begin
            st_nxt.parity_fault_flag = 1'b0;
            st_nxt.armed[0]          = 1'b0;
          end
          // tx done and rx mark not writable
          st_nxt.tx_addr_mark_bit = pwdata[`SSBG_ST_TXMARK];
        end
        `SSBG_OFF_DIVISOR: st_nxt.bit_rate_divisor = pwdata[7:0];
        `SSBG_OFF_CONTROL: st_nxt.control          = pwdata[7:0];
        `SSBG_OFF_TXHOLD:  st_nxt.tx_holding_reg   = pwdata[7:0];
        default: ;
      endcase
    end

    if (dma_wr) begin
      st_nxt.tx_holding_reg = dma_wdata;
      st_nxt.tx_empty_flag  = 1'b0;
      st_nxt.tx_done_flag   = 1'b0;
    end

    if (dma_rd) begin
      st_nxt.rx_full_flag = 1'b0;
    end

    if (tx_load) begin
      st_nxt.tx_shift_reg  = st_r.tx_holding_reg;
      st_nxt.tx_empty_flag = 1'b1;
      // mark appended only in async multiprocessor format
      st_nxt.tx_mark_out   = mp_async & st_r.tx_addr_mark_bit;
    end

    // empty at final bit ends transmission
    if (tx_last_bit && st_r.tx_empty_flag) begin
      st_nxt.tx_done_flag = 1'b1;
    end

    // receive completion
    // errors and receiver off leave buffer alone
    // receiver off leaves error flags alone
    if (rx_take) begin
      if (st_r.rx_full_flag) begin
        st_nxt.overrun_flag = 1'b1;
      end else begin
        // data copied even on framing fault
        st_nxt.rx_buffer_reg = rx_data;
        if (fer_hit) begin
          st_nxt.framing_fault_flag = 1'b1;
        end
        // parity fault, data kept, rx full left clear
        if (per_hit) begin
          st_nxt.parity_fault_flag = 1'b1;
        end
        if (!fer_hit && !per_hit) begin
          st_nxt.rx_full_flag = 1'b1;
        end
        if (mp_async) begin
          st_nxt.rx_addr_mark_bit = rx_mark_bit;
        end
      end
    end

    if (!st_nxt.control[`SSBG_CT_TXON]) begin
      st_nxt.tx_empty_flag = 1'b1;
      st_nxt.tx_done_flag  = 1'b1;
    end

    // baud generator
    // private divisor and counters of this channel
    // reload from divisor at each expiry
    // prescale, divide, then sub count per bit
    if (st_r.pre_cnt >= pre_lim) begin
      st_nxt.pre_cnt = 6'h00;
      if (st_r.div_cnt == 8'h00) begin
        st_nxt.div_cnt = st_r.bit_rate_divisor;
        st_nxt.sample_tick = st_r.sub_cnt[0];
        if (st_r.sub_cnt >= sub_lim) begin
          st_nxt.sub_cnt  = 5'h00;
          st_nxt.bit_tick = 1'b1;
        end else begin
          st_nxt.sub_cnt = st_r.sub_cnt + 5'h01;
        end
      end else begin
        st_nxt.div_cnt = st_r.div_cnt - 8'h01;
      end
    end else begin
      st_nxt.pre_cnt = st_r.pre_cnt + 6'h01;
    end

    // standby returns flags, divisor and control to reset values
    // standby sets tx empty
    if (standby) begin
      {st_nxt.tx_empty_flag, st_nxt.rx_full_flag, st_nxt.overrun_flag,
       st_nxt.framing_fault_flag, st_nxt.parity_fault_flag,
       st_nxt.tx_done_flag, st_nxt.rx_addr_mark_bit,
       st_nxt.tx_addr_mark_bit} = `SSBG_RST_STATUS;
      st_nxt.armed            = 5'h00;
      st_nxt.bit_rate_divisor = `SSBG_RST_DIVISOR;
      st_nxt.control          = `SSBG_RST_CONTROL;
    end

    // error flags halt receive, and transmit in sync mode
    st_nxt.rx_block    = st_nxt.overrun_flag | st_nxt.framing_fault_flag |
                         st_nxt.parity_fault_flag;
    st_nxt.tx_block    = st_nxt.rx_block & st_nxt.control[`SSBG_CT_SYNC];
    st_nxt.tx_start_ok = ~st_nxt.tx_empty_flag & ~st_nxt.tx_block &
                         st_nxt.control[`SSBG_CT_TXON];
  end

  // -------------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------------
  // power-on reset values are constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      {st_r.tx_empty_flag, st_r.rx_full_flag, st_r.overrun_flag,
       st_r.framing_fault_flag, st_r.parity_fault_flag, st_r.tx_done_flag,
       st_r.rx_addr_mark_bit, st_r.tx_addr_mark_bit} <= `SSBG_RST_STATUS;
      st_r.bit_rate_divisor <= `SSBG_RST_DIVISOR;
      st_r.control          <= `SSBG_RST_CONTROL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata        = st_r.prdata;
  assign pready        = st_r.pready;
  assign pslverr       = st_r.pslverr;
  assign dma_rdata     = st_r.rx_buffer_reg;
  assign tx_shift_data = st_r.tx_shift_reg;
  assign tx_mark_out   = st_r.tx_mark_out;
  assign tx_start_ok   = st_r.tx_start_ok;
  assign rx_block      = st_r.rx_block;
  assign sample_tick   = st_r.sample_tick;
  assign bit_tick      = st_r.bit_tick;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  default clocking ck @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TXE_ON_LOAD: assert property (
    tx_load |=> st_r.tx_empty_flag)
    else $error("tx empty not set after shift load");

  AST_TXE_DMA_CLR: assert property (
    dma_wr && !tx_load && !standby &&
    !(wr_acc && (paddr == `SSBG_OFF_CONTROL)) &&
    !(tx_last_bit && st_r.tx_empty_flag) &&
    st_r.control[`SSBG_CT_TXON]
    |=> !st_r.tx_empty_flag && !st_r.tx_done_flag)
    else $error("dma write did not clear tx empty and tx done");

  AST_RXF_GOOD: assert property (
    rx_take && !st_r.rx_full_flag && !fer_hit && !per_hit && !standby
    |=> st_r.rx_full_flag && (st_r.rx_buffer_reg == $past(rx_data)))
    else $error("clean character not stored with rx full");

  AST_OVR_KEEP: assert property (
    rx_take && st_r.rx_full_flag && !standby
    |=> st_r.overrun_flag &&
        (st_r.rx_buffer_reg == $past(st_r.rx_buffer_reg)))
    else $error("overrun not flagged or buffer overwritten");

  AST_FER_COPY: assert property (
    rx_take && !st_r.rx_full_flag && fer_hit && !dma_rd && !standby
    |=> st_r.framing_fault_flag && !st_r.rx_full_flag &&
        (st_r.rx_buffer_reg == $past(rx_data)))
    else $error("framing fault handling wrong");

  AST_ERR_BLOCK: assert property (
    err_any |-> rx_block && !(sync_mode && tx_start_ok))
    else $error("error flags do not halt the channel");

  AST_DIV_STANDBY: assert property (
    standby |=> (st_r.bit_rate_divisor == 8'hff) &&
                st_r.tx_empty_flag && !st_r.rx_full_flag)
    else $error("standby did not restore divisor and flags");

  AST_TX_DONE_FLAG_END: assert property (
    tx_last_bit && st_r.tx_empty_flag |=> st_r.tx_done_flag)
    else $error("tx done not set at end with empty holding reg");

endmodule // ssbg_top

/* tb/ssbg_line_model.sv */
// ---------------------------------------------------------------------------
// frame side model for the serial status flags and baud generator
// ---------------------------------------------------------------------------
// plays the tx and rx shifters that face the remote station
// assumes one-cycle event pulses on pclk, driven after the rising edge
module ssbg_line_model (
  input  wire logic       pclk,          // system clock
  input  wire logic       presetn,       // async reset, active low
  input  wire logic       tx_go,         // bench lets the shifter run
  input  wire logic       tx_start_ok,   // holding reg may be loaded
  output logic            tx_load,       // take the holding reg
  output logic            tx_last_bit,   // final bit of character sent
  output logic            rx_done,       // character finished
  output logic      [7:0] rx_data,       // received byte
  output logic            rx_parity_bit, // received parity bit
  output logic            rx_stop_bit,   // first stop bit
  output logic            rx_mark_bit    // received multiproc bit
);
  timeunit 1ns;
  timeprecision 1ps;
  int busy = 0;

  // quiet lines at time zero
  initial begin
    {tx_load, tx_last_bit, rx_done} = 3'h0;
    {rx_data, rx_parity_bit, rx_stop_bit, rx_mark_bit} = 11'h000;
  end

  // shifter: load when allowed, end the character 20 cycles later
  always @(posedge pclk) begin
    tx_last_bit <= (busy == 1);
    tx_load     <= (busy == 0) && tx_go && presetn && tx_start_ok === 1'b1;
    if (busy > 0)
      busy <= busy - 1;
    else if (tx_go && presetn && tx_start_ok === 1'b1)
      busy <= 20;
  end

  // one finished character; lines show the inverse once it is gone
  task automatic send(input logic [7:0] d, input logic s, p, m);
    @(posedge pclk);
    rx_done <= 1'b1;
    {rx_data, rx_stop_bit, rx_parity_bit, rx_mark_bit} <= {d, s, p, m};
    @(posedge pclk);
    rx_done <= 1'b0;
    {rx_data, rx_stop_bit, rx_parity_bit, rx_mark_bit} <= ~{d, s, p, m};
  endtask
endmodule // ssbg_line_model

/* tb/testbench.sv */
// ---------------------------------------------------------------------------
// testbench for the serial status flags and baud generator
// ---------------------------------------------------------------------------
// drives apb, dma and standby; checks flags, registers and bit time
// assumes the line model plays the frame shifters
`include "ssbg_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("BAD %0t got %h exp %h", $time, (a), (b)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [11:0] a;
    logic [31:0] d;
    logic [7:0]  q;
    logic        e;
  } ssbg_row_s;
  localparam logic [11:0] ST = `SSBG_OFF_STATUS;
  localparam logic [11:0] DV = `SSBG_OFF_DIVISOR;
  localparam logic [11:0] CT = `SSBG_OFF_CONTROL;
  logic        pclk = 1'b0, presetn = 1'b0, tx_go = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        standby = 1'b0, dma_wr = 1'b0, dma_rd = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [7:0]  dma_wdata = 8'h00, dma_rdata, tx_shift_data, rx_data;
  logic        pready, pslverr, tx_load, tx_last_bit, tx_mark_out;
  logic        tx_start_ok, rx_done, rx_parity_bit, rx_stop_bit;
  logic        rx_mark_bit, rx_block, sample_tick, bit_tick, er;
  int          fails = 0, n_tests = 0, c, s;
  // write, read back, expected byte and error
  ssbg_row_s   rows [7] = '{
    '{DV, 32'hffff_ff00, 8'h00, 1'b0},
    '{DV, 32'h0000_00ff, 8'hff, 1'b0},
    '{DV, 32'h0000_005a, 8'h5a, 1'b0},
    '{ST, 32'h0000_00fe, 8'h84, 1'b0},
    '{ST, 32'h0000_0001, 8'h85, 1'b0},
    '{`SSBG_OFF_RXBUF, 32'h0000_0033, 8'h00, 1'b0},
    '{12'h030, 32'h0000_00ff, 8'h00, 1'b1}
  };

  // 200 MHz system clock
  always #2.5 pclk = ~pclk;

  ssbg_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .standby, .dma_wr, .dma_wdata, .dma_rd,
    .dma_rdata, .tx_load, .tx_last_bit, .tx_shift_data, .tx_mark_out,
    .tx_start_ok, .rx_done, .rx_data, .rx_parity_bit, .rx_stop_bit,
    .rx_mark_bit, .rx_block, .sample_tick, .bit_tick);

  ssbg_line_model lm (.pclk, .presetn, .tx_go, .tx_start_ok, .tx_load,
    .tx_last_bit, .rx_done, .rx_data, .rx_parity_bit, .rx_stop_bit,
    .rx_mark_bit);

  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // read one register and compare its byte
  task automatic rs(input logic [11:0] a, input logic [7:0] q);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, {24'h000000, q})
  endtask

  // set control, then time a whole bit period in clocks
  task automatic baud(input logic [7:0] ct, input int exp, input int ns);
    apb(1'b1, CT, {24'h000000, ct});
    repeat (3) begin
      c = 0;
      s = 0;
      do begin
        @(negedge pclk);
        c++;
        s += sample_tick;
      end while (bit_tick !== 1'b1 && c < 9000);
    end
    `CHK(c, exp)
    `CHK(s, ns)
  endtask

  // counts and verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // cut a hang short
  initial begin
    #400us;
    fails++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // ordinary register cases
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0000_0000);
      `CHK(rd, {24'h000000, rows[i].q})
      `CHK(er, rows[i].e)
    end
    // transmit: dma write, shifter load, end of character
    apb(1'b1, CT, 32'h0000_0009);
    @(posedge pclk);
    dma_wr    <= 1'b1;
    dma_wdata <= 8'hc3;
    @(posedge pclk);
    dma_wr <= 1'b0;
    rs(ST, 8'h01);
    tx_go <= 1'b1;
    @(negedge pclk iff tx_load === 1'b1);
    @(negedge pclk);
    `CHK(tx_shift_data, 8'hc3)
    `CHK(tx_mark_out, 1'b1)
    rs(ST, 8'h81);
    repeat (25) @(posedge pclk);
    rs(ST, 8'h85);
    tx_go <= 1'b0;
    // receive: clean, overrun, blocked, receiver off, dma read
    apb(1'b1, CT, 32'h0000_000a);
    lm.send(8'h3c, 1'b1, 1'b0, 1'b1);
    rs(ST, 8'hc7);
    lm.send(8'h99, 1'b1, 1'b0, 1'b0);
    lm.send(8'h11, 1'b1, 1'b0, 1'b0);
    rs(ST, 8'he7);
    `CHK(dma_rdata, 8'h3c)
    `CHK(rx_block, 1'b1)
    apb(1'b1, CT, 32'h0000_0008);
    rs(ST, 8'he7);
    @(posedge pclk);
    dma_rd <= 1'b1;
    @(posedge pclk);
    dma_rd <= 1'b0;
    rs(ST, 8'ha7);
    apb(1'b1, ST, 32'h0000_00df);
    rs(ST, 8'h87);
    `CHK(rx_block, 1'b0)
    // parity and framing faults keep data but leave rx full clear
    apb(1'b1, CT, 32'h0000_0012);
    lm.send(8'h01, 1'b1, 1'b0, 1'b0);
    rs(ST, 8'h8f);
    `CHK(dma_rdata, 8'h01)
    apb(1'b1, ST, 32'h0000_00f7);
    rs(ST, 8'h87);
    lm.send(8'h55, 1'b0, 1'b0, 1'b0);
    rs(ST, 8'h97);
    `CHK(dma_rdata, 8'h55)
    // sync mode with a fault held blocks transmit
    apb(1'b1, CT, 32'h0000_0005);
    dma_wr <= 1'b1;
    @(posedge pclk);
    dma_wr <= 1'b0;
    rs(CT, 8'h05);
    `CHK(tx_start_ok, 1'b0)
    apb(1'b1, CT, 32'h0000_0001);
    rs(CT, 8'h01);
    `CHK(tx_start_ok, 1'b1)
    // bit time for each prescale code, then one sync case
    apb(1'b1, DV, 32'h0000_0002);
    for (int k = 0; k < 4; k++) begin
      baud({k[1:0], 6'h00}, 96 << (2 * k), 16);
    end
    baud(8'h44, 48, 2);
    // standby, then a second reset, both restore defaults
    @(posedge pclk);
    standby <= 1'b1;
    @(posedge pclk);
    standby <= 1'b0;
    rs(ST, 8'h84);
    rs(DV, 8'hff);
    rs(CT, 8'h00);
    apb(1'b1, DV, 32'h0000_0010);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rs(DV, 8'hff);
    rs(ST, 8'h84);
    tally_and_finish();
  end
endmodule // testbench
